// ### core/sfc_cfg.svh
// register offsets, field positions, reset values and codes of the sequencer/fifo block
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// byte offsets on the register port
`define SFC_OFF_SEQ_CONFIG 16'h2004
`define SFC_OFF_FIFO_CONFIG 16'h2008
`define SFC_OFF_CHECKSUM 16'h2060
`define SFC_OFF_WATCHDOG 16'h2068
`define SFC_OFF_QUEUE_READ 16'h206c
`define SFC_OFF_CMD_WRITE 16'h2070
`define SFC_OFF_SLEEP_LOCK 16'h2118
`define SFC_OFF_SLEEP_TRIG 16'h211c
`define SFC_OFF_SEQ_ZERO 16'h21cc
`define SFC_OFF_SEQ_TWO 16'h21d0
`define SFC_OFF_STORE_ADDR 16'h21d4
`define SFC_OFF_QUEUE_COUNT 16'h2200

// field positions
`define SFC_SRC_HI 15
`define SFC_SRC_LO 13
`define SFC_QEN_BIT 11
`define SFC_RUN_BIT 0
`define SFC_STOP_BIT 1
`define SFC_HALTED_BIT 8
`define SFC_INFO_CNT_HI 26
`define SFC_INFO_CNT_LO 16
`define SFC_INFO_BASE_HI 10
`define SFC_INFO_BASE_LO 0

// reset values
`define SFC_RST_FIFO_CONFIG 16'h1010
`define SFC_RST_CHECKSUM 8'h01
`define SFC_RST_STOP 1'b1

// codes
`define SFC_SLEEP_PASSWORD 20'ha47e5
`define SFC_CRC_POLY 8'h07
`define SFC_SRC_DFT 3'h2
`define SFC_SRC_SINC2 3'h3
`define SFC_SRC_VAR 3'h4
`define SFC_SRC_MEAN 3'h5

// channel ids placed in data words
`define SFC_CH_ADC 5'h00
`define SFC_CH_DFT_RE 5'h01
`define SFC_CH_DFT_IM 5'h02
`define SFC_CH_SINC2 5'h03
`define SFC_CH_VAR_LO 5'h04
`define SFC_CH_VAR_HI 5'h05
`define SFC_CH_MEAN 5'h06

`endif

// ### core/sfc_pkg.sv
// types shared by the sequencer/fifo block
package sfc_pkg;
  // sequencer fetch state
  typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_HALT} sfc_state_t;
  // data queue source selector
  typedef logic [2:0] sfc_src_t;
endpackage : sfc_pkg

// ### core/sfc_top.sv
// sequencer command store, result queue and their control registers
//
// Functional notes
// - other source codes queue calibrated adc samples
// - code 010 queues dft real/imag words
// - code 011 queues 16-bit sinc2 words
// - code 100 queues variance in two words
// - code 101 queues 16-bit mean words
// - queue disabled means reset, empty, blocked
// - crc-8 over executed commands, resets 0x01
// - timeout counter readable as 30 bits
// - reading empty result queue returns zero
// - command write when full is dropped
// - password value unlocks sleep trigger register
// - armed trigger sleeps at sequence end
// - sequence zero base and count bound fetch
// - sequence two base and count bound fetch
// - commands stored at command store pointer
// - run bit fetches and executes commands
// - stop_on_underflow halts, else retry fetch
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_top
  import sfc_pkg::*;
#(
  parameter int DATA_DEPTH = 64,
  parameter int CMD_DEPTH = 2048
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  input wire logic [1:0] seq_id,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  input wire logic dft_valid,
  input wire logic [17:0] dft_real,
  input wire logic [17:0] dft_imag,
  input wire logic sinc2_valid,
  input wire logic [15:0] sinc2_data,
  input wire logic var_valid,
  input wire logic [29:0] var_data,
  input wire logic mean_valid,
  input wire logic [15:0] mean_data,
  input wire logic [1:0] seq_trigger,
  output logic cmd_valid_q,
  output logic [31:0] cmd_word_q,
  output logic seq_done_q,
  output logic sleep_enter_q,
  output logic result_queue_empty_q
);

  //--------
  // local sizes
  //--------
  localparam int DAW = $clog2(DATA_DEPTH);
  localparam int CAW = $clog2(CMD_DEPTH);
  localparam logic [DAW:0] DATA_FULL = DATA_DEPTH[DAW:0];
  localparam logic [CAW:0] CMD_FULL = CMD_DEPTH[CAW:0];

  //--------
  // helpers
  //--------
  // address match, used for every strobe decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  // crc-8 over a 32-bit command word, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [31:0] w);
    logic [7:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      if (r[7] ^ w[i]) begin
        r = {r[6:0], 1'b0} ^ `SFC_CRC_POLY;
      end else begin
        r = {r[6:0], 1'b0};
      end
    end
    crc8 = r;
  endfunction : crc8

  // build a queue word: seq id, channel id, 18-bit payload
  function automatic logic [31:0] qword(input logic [1:0] s, input logic [4:0] ch,
                                        input logic [17:0] d);
    qword = {7'h00, s, ch, d};
  endfunction : qword

  //--------
  // register state
  //--------
  logic [15:0] fifo_cfg_q; // source, enable and reserved bits
  logic sequencer_run_q; // software run bit
  logic stop_on_underflow_q; // halt on empty fetch
  logic [19:0] sleep_unlock_password_q; // last written lock value
  logic sleep_request_bit_q; // sleep armed
  logic [10:0] seq_zero_base_q;
  logic [10:0] seq_zero_count_q;
  logic [10:0] seq_two_base_q;
  logic [10:0] seq_two_count_q;
  logic [10:0] command_store_pointer_q; // next store slot, full 11-bit field
  logic [7:0] crc_q; // running checksum
  logic [29:0] timeout_q; // timeout counter
  sfc_state_t state_q;

  // decoded control
  sfc_src_t result_source_select;
  logic result_queue_enable;
  logic sleep_unlocked;
  assign result_source_select = fifo_cfg_q[`SFC_SRC_HI:`SFC_SRC_LO];
  assign result_queue_enable = fifo_cfg_q[`SFC_QEN_BIT];
  assign sleep_unlocked = (sleep_unlock_password_q == `SFC_SLEEP_PASSWORD);

  // write strobes
  logic wr_fifo_cfg, wr_seq_cfg, wr_lock, wr_trig, wr_zero, wr_two, wr_addr, wr_cmd;
  assign wr_fifo_cfg = reg_wr && hit(reg_addr, `SFC_OFF_FIFO_CONFIG);
  assign wr_seq_cfg = reg_wr && hit(reg_addr, `SFC_OFF_SEQ_CONFIG);
  assign wr_lock = reg_wr && hit(reg_addr, `SFC_OFF_SLEEP_LOCK);
  assign wr_trig = reg_wr && hit(reg_addr, `SFC_OFF_SLEEP_TRIG);
  assign wr_zero = reg_wr && hit(reg_addr, `SFC_OFF_SEQ_ZERO);
  assign wr_two = reg_wr && hit(reg_addr, `SFC_OFF_SEQ_TWO);
  assign wr_addr = reg_wr && hit(reg_addr, `SFC_OFF_STORE_ADDR);
  assign wr_cmd = reg_wr && hit(reg_addr, `SFC_OFF_CMD_WRITE);

  //--------
  // configuration registers
  //--------
  // fifo config, low 16 bits stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fifo_cfg_q <= `SFC_RST_FIFO_CONFIG;
    end else if (wr_fifo_cfg) begin
      fifo_cfg_q <= reg_wdata[15:0];
    end
  end

  // sequencer run and halt-on-empty bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sequencer_run_q <= 1'b0;
      stop_on_underflow_q <= `SFC_RST_STOP;
    end else if (wr_seq_cfg) begin
      sequencer_run_q <= reg_wdata[`SFC_RUN_BIT];
      stop_on_underflow_q <= reg_wdata[`SFC_STOP_BIT];
    end
  end

  // sleep lock: a wrong value relocks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sleep_unlock_password_q <= 20'h00000;
    end else if (wr_lock) begin
      sleep_unlock_password_q <= reg_wdata[19:0];
    end
  end

  // sleep trigger only moves while unlocked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sleep_request_bit_q <= 1'b0;
    end else if (wr_trig && sleep_unlocked) begin
      sleep_request_bit_q <= reg_wdata[0];
    end
  end

  // sequence descriptors
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq_zero_base_q <= 11'h000;
      seq_zero_count_q <= 11'h000;
      seq_two_base_q <= 11'h000;
      seq_two_count_q <= 11'h000;
    end else begin
      if (wr_zero) begin
        seq_zero_base_q <= reg_wdata[`SFC_INFO_BASE_HI:`SFC_INFO_BASE_LO];
        seq_zero_count_q <= reg_wdata[`SFC_INFO_CNT_HI:`SFC_INFO_CNT_LO];
      end
      if (wr_two) begin
        seq_two_base_q <= reg_wdata[`SFC_INFO_BASE_HI:`SFC_INFO_BASE_LO];
        seq_two_count_q <= reg_wdata[`SFC_INFO_CNT_HI:`SFC_INFO_CNT_LO];
      end
    end
  end

  //--------
  // command store
  //--------
  logic [31:0] cmd_mem [CMD_DEPTH]; // command sram
  logic [CAW:0] cmd_cnt_q; // words queued and not yet fetched
  logic [CAW-1:0] fetch_ptr_q; // next fetch slot
  logic cmd_accept;
  logic fetch_now; // a command is taken this cycle
  logic fetch_from_queue; // the taken command was a queued one
  assign cmd_accept = wr_cmd && (cmd_cnt_q != CMD_FULL);

  // store at the pointer; the pointer steps so a burst lands in order
  always_ff @(posedge clk_sys) begin
    if (cmd_accept) begin
      cmd_mem[CAW'(command_store_pointer_q)] <= reg_wdata;
    end
  end

  // store pointer: software load wins, accepted writes step it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      command_store_pointer_q <= '0;
    end else if (wr_addr) begin
      command_store_pointer_q <= reg_wdata[10:0];
    end else if (cmd_accept) begin
      command_store_pointer_q <= command_store_pointer_q + 11'h001;
    end
  end

  // queued command count; accept and fetch may coincide
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_cnt_q <= '0;
    end else begin
      unique case ({cmd_accept, fetch_now && fetch_from_queue})
        2'b10: cmd_cnt_q <= cmd_cnt_q + 1'b1;
        2'b01: cmd_cnt_q <= cmd_cnt_q - 1'b1;
        default: cmd_cnt_q <= cmd_cnt_q;
      endcase
    end
  end

  //--------
  // sequencer
  //--------
  logic seq_active_q; // a triggered sequence is running
  logic [10:0] remain_q; // commands left in the sequence
  logic seq_start;
  logic [10:0] start_base, start_count;
  assign seq_start = |seq_trigger;
  // sequence zero wins when both fire together
  assign start_base = seq_trigger[0] ? seq_zero_base_q : seq_two_base_q;
  assign start_count = seq_trigger[0] ? seq_zero_count_q : seq_two_count_q;

  assign fetch_from_queue = !seq_active_q;
  assign fetch_now = (state_q == SQ_FETCH) && sequencer_run_q && !seq_start &&
                     (seq_active_q ? (remain_q != 11'h000) : (cmd_cnt_q != '0));

  // fetch state: halt is left only by clearing the run bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= SQ_IDLE;
    end else begin
      unique case (state_q)
        SQ_IDLE: begin
          if (sequencer_run_q) begin
            state_q <= SQ_FETCH;
          end
        end
        SQ_FETCH: begin
          if (!sequencer_run_q) begin
            state_q <= SQ_IDLE;
          end else if (!seq_active_q && cmd_cnt_q == '0 && !seq_start &&
                       stop_on_underflow_q) begin
            state_q <= SQ_HALT;
          end
        end
        SQ_HALT: begin
          if (!sequencer_run_q) begin
            state_q <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  // fetch pointer and sequence bounds
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_ptr_q <= '0;
      remain_q <= 11'h000;
      seq_active_q <= 1'b0;
    end else if (seq_start) begin
      fetch_ptr_q <= CAW'(start_base);
      remain_q <= start_count;
      seq_active_q <= 1'b1;
    end else begin
      if (fetch_now) begin
        fetch_ptr_q <= fetch_ptr_q + 1'b1;
      end
      if (seq_active_q && (remain_q == 11'h000 || (fetch_now && remain_q == 11'h001))) begin
        seq_active_q <= 1'b0; // bound reached
      end
      if (fetch_now && seq_active_q) begin
        remain_q <= remain_q - 11'h001;
      end
    end
  end

  // executed command out, checksum over it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_valid_q <= 1'b0;
      cmd_word_q <= 32'h00000000;
      crc_q <= `SFC_RST_CHECKSUM;
    end else begin
      cmd_valid_q <= fetch_now;
      if (fetch_now) begin
        cmd_word_q <= cmd_mem[fetch_ptr_q];
        crc_q <= crc8(crc_q, cmd_mem[fetch_ptr_q]);
      end
    end
  end

  // end of sequence and sleep entry; relies on the sleep command being last
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq_done_q <= 1'b0;
      sleep_enter_q <= 1'b0;
    end else begin
      seq_done_q <= 1'b0;
      sleep_enter_q <= 1'b0;
      if (seq_active_q && !seq_start &&
          (remain_q == 11'h000 || (fetch_now && remain_q == 11'h001))) begin
        seq_done_q <= 1'b1;
        sleep_enter_q <= sleep_request_bit_q;
      end
    end
  end

  // timeout counter runs while fetching, restarts with a sequence
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timeout_q <= 30'h00000000;
    end else if (seq_start) begin
      timeout_q <= 30'h00000000;
    end else if (state_q == SQ_FETCH) begin
      timeout_q <= timeout_q + 30'h00000001;
    end
  end

  //--------
  // result queue
  //--------
  logic [31:0] data_mem [DATA_DEPTH]; // result sram
  logic [DAW-1:0] wp_q, rp_q;
  logic [DAW:0] dcnt_q;
  logic [31:0] pend_q; // second word of a two-word result
  logic pend_q_valid;
  logic push;
  logic [31:0] push_word;
  logic [31:0] second_word;
  logic second_needed;
  logic pop;
  assign pop = reg_rd && hit(reg_addr, `SFC_OFF_QUEUE_READ) && (dcnt_q != '0);

  // pick the word for the selected source; a pending word goes first,
  // so a new sample in that cycle is lost (two-word sources need a gap)
  always_comb begin
    push = 1'b0;
    push_word = 32'h00000000;
    second_word = 32'h00000000;
    second_needed = 1'b0;
    if (pend_q_valid) begin
      push = 1'b1;
      push_word = pend_q;
    end else begin
      unique case (result_source_select)
        `SFC_SRC_DFT: begin
          push = dft_valid;
          push_word = qword(seq_id, `SFC_CH_DFT_RE, dft_real);
          second_word = qword(seq_id, `SFC_CH_DFT_IM, dft_imag);
          second_needed = dft_valid;
        end
        `SFC_SRC_SINC2: begin
          push = sinc2_valid;
          push_word = qword(seq_id, `SFC_CH_SINC2, {2'b00, sinc2_data});
        end
        `SFC_SRC_VAR: begin
          push = var_valid;
          push_word = qword(seq_id, `SFC_CH_VAR_LO, {3'h0, var_data[14:0]});
          second_word = qword(seq_id, `SFC_CH_VAR_HI, {3'h0, var_data[29:15]});
          second_needed = var_valid;
        end
        `SFC_SRC_MEAN: begin
          push = mean_valid;
          push_word = qword(seq_id, `SFC_CH_MEAN, {2'b00, mean_data});
        end
        default: begin
          push = adc_valid;
          push_word = qword(seq_id, `SFC_CH_ADC, {2'b00, adc_data});
        end
      endcase
    end
  end

  logic push_ok;
  assign push_ok = push && result_queue_enable && (dcnt_q != DATA_FULL);

  // pending second word, dropped when the queue is disabled
  always_ff @(posedge clk_sys) begin
    if (rst || !result_queue_enable) begin
      pend_q_valid <= 1'b0;
      pend_q <= 32'h00000000;
    end else begin
      pend_q_valid <= second_needed;
      pend_q <= second_word;
    end
  end

  // queue storage
  always_ff @(posedge clk_sys) begin
    if (push_ok) begin
      data_mem[wp_q] <= push_word;
    end
  end

  // pointers and count, returned to empty while disabled
  always_ff @(posedge clk_sys) begin
    if (rst || !result_queue_enable) begin
      wp_q <= '0;
      rp_q <= '0;
      dcnt_q <= '0;
    end else begin
      if (push_ok) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      unique case ({push_ok, pop})
        2'b10: dcnt_q <= dcnt_q + 1'b1;
        2'b01: dcnt_q <= dcnt_q - 1'b1;
        default: dcnt_q <= dcnt_q;
      endcase
    end
  end

  // registered empty flag, tracks the count's next value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_queue_empty_q <= 1'b1;
    end else if (!result_queue_enable) begin
      result_queue_empty_q <= 1'b1;
    end else begin
      result_queue_empty_q <= (dcnt_q == '0 && !push_ok) ||
                              (dcnt_q == {{DAW{1'b0}}, 1'b1} && pop && !push_ok);
    end
  end

  //--------
  // read data, valid in the cycle after the strobe only
  //--------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000; // unmapped and write-only read zero
    unique case (reg_addr)
      `SFC_OFF_SEQ_CONFIG: begin
        rd_mux = {23'h0, state_q == SQ_HALT, 6'h00, stop_on_underflow_q, sequencer_run_q};
      end
      `SFC_OFF_FIFO_CONFIG: rd_mux = {16'h0000, fifo_cfg_q};
      `SFC_OFF_CHECKSUM: rd_mux = {24'h000000, crc_q};
      `SFC_OFF_WATCHDOG: rd_mux = {2'b00, timeout_q};
      `SFC_OFF_QUEUE_READ: rd_mux = (dcnt_q != '0) ? data_mem[rp_q] : 32'h00000000;
      `SFC_OFF_SLEEP_LOCK: rd_mux = {12'h000, sleep_unlock_password_q};
      `SFC_OFF_SLEEP_TRIG: rd_mux = {31'h0, sleep_request_bit_q};
      `SFC_OFF_SEQ_ZERO: rd_mux = {5'h0, seq_zero_count_q, 5'h0, seq_zero_base_q};
      `SFC_OFF_SEQ_TWO: rd_mux = {5'h0, seq_two_count_q, 5'h0, seq_two_base_q};
      `SFC_OFF_STORE_ADDR: rd_mux = {21'h0, command_store_pointer_q};
      `SFC_OFF_QUEUE_COUNT: rd_mux = {5'h0, 11'(dcnt_q), 16'h0000};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // holds zero except in the cycle after a read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end

endmodule : sfc_top

// ### sim/sfc_top_checker.sv
// port assertions of the sequencer/fifo block
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_top_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic cmd_valid_q,
  input wire logic [31:0] cmd_word_q,
  input wire logic seq_done_q,
  input wire logic sleep_enter_q,
  input wire logic result_queue_empty_q
);
  // --------
  // shadow state seen from the register port
  // --------
  logic en_q; // queue enable as last written
  logic unl_q; // sleep trigger unlocked
  logic trig_q; // sleep request bit as accepted
  // enable shadow
  always_ff @(posedge clk_sys) begin
    if (rst) en_q <= 1'b0;
    else if (reg_wr && reg_addr == `SFC_OFF_FIFO_CONFIG) en_q <= reg_wdata[`SFC_QEN_BIT];
  end
  // lock shadow
  always_ff @(posedge clk_sys) begin
    if (rst) unl_q <= 1'b0;
    else if (reg_wr && reg_addr == `SFC_OFF_SLEEP_LOCK)
      unl_q <= (reg_wdata[19:0] == `SFC_SLEEP_PASSWORD);
  end
  // trigger shadow
  always_ff @(posedge clk_sys) begin
    if (rst) trig_q <= 1'b0;
    else if (reg_wr && reg_addr == `SFC_OFF_SLEEP_TRIG && unl_q) trig_q <= reg_wdata[0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // --------
  // properties
  // --------
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata_q == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata off slot");
  property p_empty_read_zero;
    reg_rd && reg_addr == `SFC_OFF_QUEUE_READ && result_queue_empty_q |=> reg_rdata_q == 32'h0;
  endproperty
  a_empty_read_zero: assert property (p_empty_read_zero) else $error("empty read not zero");
  property p_wo_zero;
    reg_rd && reg_addr == `SFC_OFF_CMD_WRITE |=> reg_rdata_q == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("command port read back");
  property p_off_empty;
    !en_q && !$past(en_q) |-> result_queue_empty_q;
  endproperty
  a_off_empty: assert property (p_off_empty) else $error("off not empty");
  property p_reset_empty;
    $fell(rst) |-> result_queue_empty_q && !cmd_valid_q && !seq_done_q;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("bad state after reset");
  property p_sleep_done;
    sleep_enter_q |-> seq_done_q;
  endproperty
  a_sleep_done: assert property (p_sleep_done) else $error("sleep not at end");
  property p_sleep_armed;
    sleep_enter_q |-> trig_q;
  endproperty
  a_sleep_armed: assert property (p_sleep_armed) else $error("sleep without armed bit");
  property p_word_hold;
    !cmd_valid_q |-> $stable(cmd_word_q);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("command word moved");
  // main scenarios
  c_cmd: cover property (cmd_valid_q);
  c_sleep: cover property (sleep_enter_q);
  c_empty_read: cover property (reg_rd && reg_addr == `SFC_OFF_QUEUE_READ && result_queue_empty_q);
endmodule : sfc_top_checker

bind sfc_top sfc_top_checker u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .cmd_valid_q(cmd_valid_q), .cmd_word_q(cmd_word_q), .seq_done_q(seq_done_q),
  .sleep_enter_q(sleep_enter_q), .result_queue_empty_q(result_queue_empty_q));

// ### sim/sfc_top_tb.sv
// self-checking bench of the sequencer/fifo block
`timescale 1ns/1ns
`include "sfc_cfg.svh"

module sfc_top_tb;
  // --------
  // stimulus and observed signals
  // --------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] seq_id = 2'h0;
  logic [1:0] seq_trigger = 2'h0;
  logic adc_valid = 1'b0, dft_valid = 1'b0, sinc2_valid = 1'b0, var_valid = 1'b0;
  logic mean_valid = 1'b0;
  logic [15:0] adc_data = 16'h0, sinc2_data = 16'h0, mean_data = 16'h0;
  logic [17:0] dft_real = 18'h0, dft_imag = 18'h0;
  logic [29:0] var_data = 30'h0;
  logic [31:0] reg_rdata_q, cmd_word_q;
  logic cmd_valid_q, seq_done_q, sleep_enter_q, result_queue_empty_q;
  int mismatches = 0, comparisons = 0, dones = 0, sleeps = 0;
  logic [31:0] got[$]; // executed command words
  logic [7:0] crc = 8'h01; // expected checksum, same start value

  always #25 clk_sys = ~clk_sys;

  // small depths keep the full-queue case short
  sfc_top #(.DATA_DEPTH(16), .CMD_DEPTH(16)) dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .seq_id(seq_id), .adc_valid(adc_valid), .adc_data(adc_data),
    .dft_valid(dft_valid), .dft_real(dft_real), .dft_imag(dft_imag),
    .sinc2_valid(sinc2_valid), .sinc2_data(sinc2_data), .var_valid(var_valid),
    .var_data(var_data), .mean_valid(mean_valid), .mean_data(mean_data),
    .seq_trigger(seq_trigger), .cmd_valid_q(cmd_valid_q), .cmd_word_q(cmd_word_q),
    .seq_done_q(seq_done_q), .sleep_enter_q(sleep_enter_q),
    .result_queue_empty_q(result_queue_empty_q));

  // collect output pulses
  always @(posedge clk_sys) begin
    if (cmd_valid_q === 1'b1) got.push_back(cmd_word_q);
    if (seq_done_q === 1'b1) dones++;
    if (sleep_enter_q === 1'b1) sleeps++;
  end

  // --------
  // helpers
  // --------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one edge, then release all pulses
  task automatic step;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    seq_trigger <= 2'h0;
    {adc_valid, dft_valid, sinc2_valid, var_valid, mean_valid} <= 5'h0;
    #1;
  endtask : step
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    step;
    check($sformatf("reg %h", a), reg_rdata_q, e);
  endtask : rd
  // all sources fire, one is queued
  task automatic pulse_src(input logic [7:0] k);
    adc_data <= {8'h12, k};
    dft_real <= {10'h2ab, k};
    dft_imag <= {10'h154, k};
    sinc2_data <= {8'h5a, k};
    var_data <= {22'h2edcba, k};
    mean_data <= {8'hc3, k};
    {adc_valid, dft_valid, sinc2_valid, var_valid, mean_valid} <= 5'h1f;
    repeat (5) step;
  endtask : pulse_src
  function automatic logic [31:0] w(input logic [4:0] ch, input logic [17:0] d);
    return {7'h0, seq_id, ch, d};
  endfunction : w
  // crc-8, polynomial 0x07, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  // bounded wait
  task automatic wait_cmds(input int n);
    repeat (200) begin
      if (got.size() >= n) break;
      step;
    end
    repeat (3) step;
  endtask : wait_cmds

  // --------
  // scenarios
  // --------
  task automatic t_reset;
    logic [15:0] a[9] = '{`SFC_OFF_FIFO_CONFIG, `SFC_OFF_CHECKSUM, `SFC_OFF_WATCHDOG,
      `SFC_OFF_QUEUE_READ, `SFC_OFF_SLEEP_LOCK, `SFC_OFF_SLEEP_TRIG, `SFC_OFF_SEQ_ZERO,
      `SFC_OFF_SEQ_TWO, `SFC_OFF_STORE_ADDR};
    logic [31:0] v[9] = '{32'h1010, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    foreach (a[i]) rd(a[i], v[i]);
    check("empty", 32'(result_queue_empty_q), 32'h1);
  endtask : t_reset
  // widths, unmapped places, lock
  task automatic t_regs;
    wr(`SFC_OFF_SEQ_ZERO, 32'hffffffff);
    rd(`SFC_OFF_SEQ_ZERO, 32'h07ff07ff);
    wr(`SFC_OFF_SEQ_TWO, 32'hffffffff);
    rd(`SFC_OFF_SEQ_TWO, 32'h07ff07ff);
    wr(`SFC_OFF_STORE_ADDR, 32'hffffffff);
    rd(`SFC_OFF_STORE_ADDR, 32'h7ff);
    rd(`SFC_OFF_CMD_WRITE, 32'h0);
    wr(16'h2100, 32'hffffffff);
    rd(16'h2100, 32'h0);
    wr(`SFC_OFF_SLEEP_LOCK, 32'hffffffff);
    rd(`SFC_OFF_SLEEP_LOCK, 32'hfffff);
    wr(`SFC_OFF_SLEEP_TRIG, 32'h1);
    rd(`SFC_OFF_SLEEP_TRIG, 32'h0);
  endtask : t_regs
  // word layout of each source code
  task automatic t_sources;
    logic [31:0] e[$];
    for (int c = 0; c < 8; c++) begin
      seq_id <= c[1:0];
      wr(`SFC_OFF_FIFO_CONFIG, 32'h0800 | (32'(c) << 13));
      pulse_src(8'(c));
      case (c)
        2: e = {w(5'h1, dft_real), w(5'h2, dft_imag)};
        3: e = {w(5'h3, {2'h0, sinc2_data})};
        4: e = {w(5'h4, {3'h0, var_data[14:0]}), w(5'h5, {3'h0, var_data[29:15]})};
        5: e = {w(5'h6, {2'h0, mean_data})};
        default: e = {w(5'h0, {2'h0, adc_data})};
      endcase
      foreach (e[i]) rd(`SFC_OFF_QUEUE_READ, e[i]);
      rd(`SFC_OFF_QUEUE_READ, 32'h0);
    end
  endtask : t_sources
  // disabling flushes and blocks the queue
  task automatic t_disable;
    pulse_src(8'h77);
    check("empty", 32'(result_queue_empty_q), 32'h0);
    wr(`SFC_OFF_FIFO_CONFIG, 32'h0);
    step;
    check("empty", 32'(result_queue_empty_q), 32'h1);
    pulse_src(8'h78);
    check("empty", 32'(result_queue_empty_q), 32'h1);
    wr(`SFC_OFF_FIFO_CONFIG, 32'h0800);
    rd(`SFC_OFF_QUEUE_READ, 32'h0);
  endtask : t_disable
  // store to full, underflow, sleep
  task automatic t_cmd;
    wr(`SFC_OFF_STORE_ADDR, 32'h0);
    for (int i = 0; i < 17; i++) wr(`SFC_OFF_CMD_WRITE, 32'ha5000000 | i);
    wr(`SFC_OFF_SEQ_CONFIG, 32'h3);
    wait_cmds(16);
    check("cmds", got.size(), 32'd16);
    foreach (got[i]) begin
      check("cmd", got[i], 32'ha5000000 | i);
      crc = crc8(crc, 32'ha5000000 | i);
    end
    rd(`SFC_OFF_SEQ_CONFIG, 32'h103);
    wr(`SFC_OFF_SEQ_CONFIG, 32'h0);
    wr(`SFC_OFF_SEQ_CONFIG, 32'h1);
    wr(`SFC_OFF_SLEEP_LOCK, `SFC_SLEEP_PASSWORD);
    wr(`SFC_OFF_SLEEP_TRIG, 32'h1);
    rd(`SFC_OFF_SLEEP_TRIG, 32'h1);
    wr(`SFC_OFF_SEQ_TWO, 32'h00020003);
    got = {};
    dones = 0;
    seq_trigger <= 2'h2;
    step;
    wait_cmds(2);
    check("seq2a", got[0], 32'ha5000003);
    check("seq2b", got[1], 32'ha5000004);
    check("done", dones, 32'd1);
    check("sleep", sleeps, 32'd1);
    rd(`SFC_OFF_SEQ_CONFIG, 32'h1);
    crc = crc8(crc8(crc, 32'ha5000003), 32'ha5000004);
    wr(`SFC_OFF_SLEEP_LOCK, 32'h0);
    wr(`SFC_OFF_SLEEP_TRIG, 32'h0);
    rd(`SFC_OFF_SLEEP_TRIG, 32'h1);
    wr(`SFC_OFF_SEQ_ZERO, 32'h0002000e);
    got = {};
    seq_trigger <= 2'h1;
    step;
    wait_cmds(2);
    check("seq0a", got[0], 32'ha500000e);
    check("seq0b", got[1], 32'ha500000f);
    check("sleep", sleeps, 32'd2);
    crc = crc8(crc8(crc, 32'ha500000e), 32'ha500000f);
    rd(`SFC_OFF_CHECKSUM, {24'h0, crc});
  endtask : t_cmd

  // --------
  // verdict and run control
  // --------
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // hang guard, far beyond the run
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    step;
    t_reset;
    t_regs;
    t_sources;
    t_disable;
    t_cmd;
    results;
  end
endmodule : sfc_top_tb
